// file: rtl/cdt_top.sv
// Debug and trace support: tracing, breakpoints, opcode tracking and background debug.
`default_nettype none
`include "cdt_regs.svh"
module cdt_top #(
    parameter logic [7:0] VEC_ILLEGAL = `CDT_VEC_ILLEGAL,
    parameter logic [7:0] VEC_TRACE   = `CDT_VEC_TRACE,
    parameter logic [7:0] VEC_LINEA   = `CDT_VEC_LINEA,
    parameter logic [7:0] VEC_LINEF   = `CDT_VEC_LINEF,
    parameter logic [7:0] VEC_EXTBKPT = `CDT_VEC_EXTBKPT
) (
    // Clock and reset
    input  wire logic                clock_in,
    input  wire logic                nrst_in,
    // Core pipeline events
    input  wire logic                instr_start_in,
    input  wire logic                mid_advance_in,
    input  wire logic                prog_fetch_in,
    input  wire logic                pipe_flush_in,
    // Instruction completion
    input  wire logic                instr_done_in,
    input  wire logic         [15:0] opcode_in,
    input  wire logic                opcode_illegal_in,
    input  wire logic                flow_change_in,
    input  wire logic          [1:0] trace_mode_in,
    // Bus and fault events
    input  wire logic                mem_access_in,
    input  wire logic                double_fault_in,
    input  wire logic                enter_background_opcode_enable_in,
    // External pins
    input  wire logic                ext_breakpoint_opcode_n_in,
    input  wire logic                dbg_sclk_in,
    input  wire logic                dbg_sdi_in,
    output logic                     dbg_sdo_out,
    // Tracking outputs
    output logic                     pipe_advance_out,
    output logic                     instruction_fetch_marker_out,
    // Exception request to the core
    output logic                     exc_valid_out,
    output logic               [7:0] exc_vector_out,
    output logic                     background_out,
    output logic                     halted_out,
    // Debugger access port to the core
    output logic                     dbg_req_valid_out,
    output cdt_pkg::cdt_req_s        dbg_req_out,
    input  wire logic                dbg_ack_in,
    input  wire logic         [15:0] dbg_rdata_in
);
    import cdt_pkg::*;

    // ------------------------------------------------------------------------
    // Pin synchronisation and decode
    // ------------------------------------------------------------------------
    logic [2:0]  pins_s;
    logic        breakpoint_opcode_s;
    logic        sclk_s;
    logic        sdi_s;
    logic        sclk_d1_q;
    logic        sclk_rise;
    cdt_class_e  opc_class;

    cdt_sync #(
        .WIDTH     (3),
        .RESET_VAL (3'h4)
    ) u_sync (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .async_in ({ext_breakpoint_opcode_n_in, dbg_sclk_in, dbg_sdi_in}),
        .sync_out (pins_s)
    );

    cdt_decode u_decode (
        .opcode_in  (opcode_in),
        .illegal_in (opcode_illegal_in),
        .class_out  (opc_class)
    );

    // Synchronised pin levels, breakpoint made active high.
    assign breakpoint_opcode_s    = ~pins_s[2];
    assign sclk_s    = pins_s[1];
    assign sdi_s     = pins_s[0];
    assign sclk_rise = sclk_s & ~sclk_d1_q;

    // Delayed serial clock for edge detection.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_d1_q <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_s;
        end
    end

    // ------------------------------------------------------------------------
    // Opcode tracking outputs
    // ------------------------------------------------------------------------
    // Both outputs are one-cycle registered copies of the pipeline events.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pipe_advance_out             <= 1'b0;
            instruction_fetch_marker_out <= 1'b0;
        end else begin
            pipe_advance_out             <= instr_start_in | mid_advance_in;
            instruction_fetch_marker_out <= prog_fetch_in | pipe_flush_in;
        end
    end

    // ------------------------------------------------------------------------
    // External breakpoint capture
    // ------------------------------------------------------------------------
    logic breakpoint_opcode_pend_q;
    logic take_breakpoint_opcode;
    logic enter_background_opcode_q;
    logic go_cmd;

    // A breakpoint seen during an access is held until the next boundary.
    assign take_breakpoint_opcode = instr_done_in & breakpoint_opcode_pend_q & ~enter_background_opcode_q;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            breakpoint_opcode_pend_q <= 1'b0;
        end else if (mem_access_in & breakpoint_opcode_s) begin
            breakpoint_opcode_pend_q <= 1'b1;
        end else if (take_breakpoint_opcode) begin
            breakpoint_opcode_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Exception selection at instruction completion
    // ------------------------------------------------------------------------
    logic       exc_hit;
    logic       to_enter_background_opcode;
    logic [7:0] exc_vec;
    logic       boundary;

    assign boundary = instr_done_in & ~enter_background_opcode_q;

    // Opcode faults win over a pending breakpoint, which wins over trace.
    always_comb begin
        exc_hit = 1'b0;
        to_enter_background_opcode = 1'b0;
        exc_vec = VEC_ILLEGAL;
        if (boundary) begin
            unique case (opc_class)
                CDT_CLS_ILLEGAL: begin
                    exc_hit = 1'b1;
                end
                CDT_CLS_BREAKPOINT_OPCODE: begin
                    to_enter_background_opcode = enter_background_opcode_enable_in;
                    exc_hit = ~enter_background_opcode_enable_in;
                end
                CDT_CLS_LINEA: begin
                    exc_hit = 1'b1;
                    exc_vec = VEC_LINEA;
                end
                CDT_CLS_LINEF: begin
                    exc_hit = 1'b1;
                    exc_vec = VEC_LINEF;
                end
                CDT_CLS_ENTER_BACKGROUND_OPCODE: begin
                    to_enter_background_opcode = enter_background_opcode_enable_in;
                    exc_hit = ~enter_background_opcode_enable_in;
                end
                CDT_CLS_NORMAL: begin
                    if (breakpoint_opcode_pend_q) begin
                        to_enter_background_opcode = enter_background_opcode_enable_in;
                        exc_hit = ~enter_background_opcode_enable_in;
                        exc_vec = VEC_EXTBKPT;
                    end else if (trace_mode_in == `CDT_TRACE_ALL) begin
                        exc_hit = 1'b1;
                        exc_vec = VEC_TRACE;
                    end else if (trace_mode_in == `CDT_TRACE_FLOW) begin
                        exc_hit = flow_change_in;
                        exc_vec = VEC_TRACE;
                    end
                end
            endcase
        end
    end

    // Registered one-cycle exception request.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            exc_valid_out  <= 1'b0;
            exc_vector_out <= 8'h00;
        end else begin
            exc_valid_out  <= exc_hit;
            exc_vector_out <= exc_hit ? exc_vec : exc_vector_out;
        end
    end

    // ------------------------------------------------------------------------
    // Background and halted state
    // ------------------------------------------------------------------------
    // Entry wins over a resume command arriving in the same cycle.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            enter_background_opcode_q <= 1'b0;
        end else if (to_enter_background_opcode | (double_fault_in & enter_background_opcode_enable_in)) begin
            enter_background_opcode_q <= 1'b1;
        end else if (go_cmd) begin
            enter_background_opcode_q <= 1'b0;
        end
    end

    // A double fault without background enabled stops the core until reset.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            halted_out <= 1'b0;
        end else if (double_fault_in & ~enter_background_opcode_enable_in) begin
            halted_out <= 1'b1;
        end
    end

    assign background_out = enter_background_opcode_q;

    // ------------------------------------------------------------------------
    // Serial frame shifter
    // ------------------------------------------------------------------------
    logic [16:0] rx_q;
    logic [16:0] tx_q;
    logic  [4:0] bit_q;
    logic        frame_done;
    logic [15:0] result_q;
    logic        busy;
    cdt_ser_e    ser_q;

    assign frame_done  = sclk_rise && (bit_q == `CDT_FRAME_BITS - 5'h01);
    assign busy        = ~enter_background_opcode_q | (ser_q == CDT_SER_WAIT);
    assign dbg_sdo_out = tx_q[16];

    // Bits shift on each rising serial clock, most significant first.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_q  <= 17'h00000;
            tx_q  <= 17'h10000;
            bit_q <= 5'h00;
        end else if (frame_done) begin
            rx_q  <= {rx_q[15:0], sdi_s};
            tx_q  <= {busy, result_q};
            bit_q <= 5'h00;
        end else if (sclk_rise) begin
            rx_q  <= {rx_q[15:0], sdi_s};
            tx_q  <= {tx_q[15:0], 1'b0};
            bit_q <= bit_q + 5'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Serial command engine
    // ------------------------------------------------------------------------
    logic [15:0] word;
    logic  [3:0] cmd_q;
    logic  [3:0] idx_q;
    logic  [1:0] left_q;
    logic [23:0] addr_q;
    logic        req_q;

    assign word   = {rx_q[14:0], sdi_s};
    assign go_cmd = frame_done && (ser_q == CDT_SER_CMD) && enter_background_opcode_q &&
                    (word[15:12] == `CDT_CMD_GO);
    assign dbg_req_valid_out = req_q;

    // Commands act only in background; anything else is ignored.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ser_q  <= CDT_SER_CMD;
            cmd_q  <= `CDT_CMD_NOP;
            idx_q  <= 4'h0;
            left_q <= 2'h0;
            addr_q <= 24'h000000;
            req_q  <= 1'b0;
        end else begin
            unique case (ser_q)
                CDT_SER_CMD: begin
                    if (frame_done && enter_background_opcode_q) begin
                        cmd_q <= word[15:12];
                        idx_q <= word[3:0];
                        if (word[15:12] == `CDT_CMD_RREG || word[15:12] == `CDT_CMD_RMEM ||
                            word[15:12] == `CDT_CMD_TEST) begin
                            req_q <= 1'b1;
                            ser_q <= CDT_SER_WAIT;
                        end else if (word[15:12] == `CDT_CMD_WREG ||
                                     word[15:12] == `CDT_CMD_WMEM) begin
                            left_q <= 2'h1;
                            ser_q  <= CDT_SER_DATA;
                        end else if (word[15:12] == `CDT_CMD_ADDR) begin
                            left_q <= `CDT_ADDR_WORDS;
                            ser_q  <= CDT_SER_DATA;
                        end
                    end
                end
                CDT_SER_DATA: begin
                    if (frame_done) begin
                        left_q <= left_q - 2'h1;
                        if (cmd_q == `CDT_CMD_ADDR) begin
                            addr_q <= {addr_q[7:0], word};
                            if (left_q == 2'h1) begin
                                ser_q <= CDT_SER_CMD;
                            end
                        end else begin
                            req_q <= 1'b1;
                            ser_q <= CDT_SER_WAIT;
                        end
                    end
                end
                CDT_SER_WAIT: begin
                    if (dbg_ack_in) begin
                        req_q <= 1'b0;
                        ser_q <= CDT_SER_CMD;
                    end
                end
            endcase
        end
    end

    // Request contents, captured with the frame that completes the command.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dbg_req_out <= '0;
        end else if (frame_done && ser_q != CDT_SER_WAIT) begin
            dbg_req_out.index <= (ser_q == CDT_SER_CMD) ? word[3:0] : idx_q;
            dbg_req_out.addr  <= addr_q;
            dbg_req_out.wdata <= word;
            unique case ((ser_q == CDT_SER_CMD) ? word[15:12] : cmd_q)
                `CDT_CMD_WREG: dbg_req_out.kind <= CDT_ACC_WREG;
                `CDT_CMD_RMEM: dbg_req_out.kind <= CDT_ACC_RMEM;
                `CDT_CMD_WMEM: dbg_req_out.kind <= CDT_ACC_WMEM;
                `CDT_CMD_TEST: dbg_req_out.kind <= CDT_ACC_TEST;
                default:       dbg_req_out.kind <= CDT_ACC_RREG;
            endcase
        end
    end

    // Read data returned by the core, captured on its acknowledge and sent in the frame after the next frame end.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            result_q <= 16'h0000;
        end else if (ser_q == CDT_SER_WAIT && dbg_ack_in) begin
            result_q <= dbg_rdata_in;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    sequence s_access_hit;
        mem_access_in && breakpoint_opcode_s && !enter_background_opcode_q;
    endsequence

    sequence s_boundary_plain;
        instr_done_in && !enter_background_opcode_q && opc_class == CDT_CLS_NORMAL && !opcode_illegal_in;
    endsequence

    pipe_adv_a: assert property ((instr_start_in || mid_advance_in) |=> pipe_advance_out)
        else $error("pipe advance missed");
    fetch_only_a: assert property (!(prog_fetch_in || pipe_flush_in)
        |=> !instruction_fetch_marker_out) else $error("fetch marker spurious");
    flush_mark_a: assert property (pipe_flush_in |=> instruction_fetch_marker_out)
        else $error("flush not marked");
    breakpoint_opcode_illegal_a: assert property (boundary && opc_class == CDT_CLS_BREAKPOINT_OPCODE && !enter_background_opcode_enable_in
        |=> exc_valid_out && exc_vector_out == VEC_ILLEGAL) else $error("breakpoint_opcode vector wrong");
    illegal_vec_a: assert property (boundary && opc_class == CDT_CLS_ILLEGAL
        |=> exc_valid_out && exc_vector_out == VEC_ILLEGAL) else $error("illegal missed");
    line_vec_a: assert property (boundary && opc_class == CDT_CLS_LINEF
        |=> exc_vector_out == VEC_LINEF && exc_vector_out != VEC_ILLEGAL) else $error("line vector");
    trace_all_a: assert property (s_boundary_plain ##0 !breakpoint_opcode_pend_q &&
        trace_mode_in == `CDT_TRACE_ALL |=> exc_valid_out && exc_vector_out == VEC_TRACE)
        else $error("trace all missed");
    flow_skip_a: assert property (s_boundary_plain ##0 !breakpoint_opcode_pend_q && !flow_change_in &&
        trace_mode_in == `CDT_TRACE_FLOW |=> !exc_valid_out) else $error("flow trace spurious");
    ext_breakpoint_opcode_a: assert property (s_access_hit ##1 (instr_done_in && opc_class == CDT_CLS_NORMAL
        && !enter_background_opcode_enable_in) |=> exc_valid_out && exc_vector_out == VEC_EXTBKPT)
        else $error("external breakpoint lost");
    enter_background_opcode_entry_a: assert property (double_fault_in && enter_background_opcode_enable_in
        |=> background_out [*2] or (background_out ##1 !background_out)) else $error("no enter_background_opcode");
    dbg_done_a: assert property (ser_q == CDT_SER_WAIT && dbg_ack_in
        |=> !dbg_req_valid_out && result_q == $past(dbg_rdata_in)) else $error("debug ack");

endmodule
`default_nettype wire

// file: rtl/cdt_regs.svh
// Constants of the debug and trace support block: opcodes, vectors, commands and framing.
`ifndef CDT_REGS_SVH
`define CDT_REGS_SVH

// ----------------------------------------------------------------------------
// Opcode decode
// ----------------------------------------------------------------------------
`define CDT_BREAKPOINT_OPCODE_LO       16'h4848
`define CDT_BREAKPOINT_OPCODE_HI       16'h484f
`define CDT_LINEA_NIB     4'ha
`define CDT_LINEF_NIB     4'hf
`define CDT_ENTER_BACKGROUND_OPCODE_OPC      16'h4aff

// ----------------------------------------------------------------------------
// Default exception vector numbers
// ----------------------------------------------------------------------------
`define CDT_VEC_ILLEGAL   8'h04
`define CDT_VEC_TRACE     8'h09
`define CDT_VEC_LINEA     8'h0a
`define CDT_VEC_LINEF     8'h0b
`define CDT_VEC_EXTBKPT   8'h0c

// ----------------------------------------------------------------------------
// Trace mode field encodings
// ----------------------------------------------------------------------------
`define CDT_TRACE_OFF     2'h0
`define CDT_TRACE_FLOW    2'h1
`define CDT_TRACE_ALL     2'h2

// ----------------------------------------------------------------------------
// Serial debug command codes, held in bits 15:12 of a command frame
// ----------------------------------------------------------------------------
`define CDT_CMD_NOP       4'h0
`define CDT_CMD_RREG      4'h1
`define CDT_CMD_WREG      4'h2
`define CDT_CMD_RMEM      4'h3
`define CDT_CMD_WMEM      4'h4
`define CDT_CMD_ADDR      4'h5
`define CDT_CMD_TEST      4'h6
`define CDT_CMD_GO        4'h7

// ----------------------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------------------
`define CDT_FRAME_BITS    5'h11
`define CDT_ADDR_WORDS    2'h2

`endif

// file: rtl/cdt_pkg.sv
// Types shared by the debug and trace support block.
`default_nettype none
package cdt_pkg;

    // Class of an instruction word as seen by the debug decoder.
    typedef enum logic [2:0] {
        CDT_CLS_NORMAL,
        CDT_CLS_ILLEGAL,
        CDT_CLS_BREAKPOINT_OPCODE,
        CDT_CLS_LINEA,
        CDT_CLS_LINEF,
        CDT_CLS_ENTER_BACKGROUND_OPCODE
    } cdt_class_e;

    // Kind of core access requested by the background debugger.
    typedef enum logic [2:0] {
        CDT_ACC_RREG,
        CDT_ACC_WREG,
        CDT_ACC_RMEM,
        CDT_ACC_WMEM,
        CDT_ACC_TEST
    } cdt_acc_e;

    // States of the serial command engine.
    typedef enum logic [1:0] {
        CDT_SER_CMD,
        CDT_SER_DATA,
        CDT_SER_WAIT
    } cdt_ser_e;

    // One debugger access handed to the core.
    typedef struct packed {
        cdt_acc_e    kind;
        logic [3:0]  index;
        logic [23:0] addr;
        logic [15:0] wdata;
    } cdt_req_s;

endpackage
`default_nettype wire

// file: rtl/cdt_sync.sv
// Two flip-flop synchroniser for a group of asynchronous inputs.
`default_nettype none
module cdt_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             nrst_in,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage is read only by the second stage.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// file: rtl/cdt_decode.sv
// Classifier of instruction words for breakpoint, line and background opcodes.
`default_nettype none
`include "cdt_regs.svh"
module cdt_decode (
    // Instruction word
    input  wire logic              [15:0] opcode_in,
    input  wire logic                     illegal_in,
    // Result
    output cdt_pkg::cdt_class_e           class_out
);
    import cdt_pkg::*;

    // Breakpoint range first, then the unimplemented lines, then the rest.
    always_comb begin
        if (opcode_in >= `CDT_BREAKPOINT_OPCODE_LO && opcode_in <= `CDT_BREAKPOINT_OPCODE_HI) begin
            class_out = CDT_CLS_BREAKPOINT_OPCODE;
        end else if (opcode_in[15:12] == `CDT_LINEA_NIB) begin
            class_out = CDT_CLS_LINEA;
        end else if (opcode_in[15:12] == `CDT_LINEF_NIB) begin
            class_out = CDT_CLS_LINEF;
        end else if (opcode_in == `CDT_ENTER_BACKGROUND_OPCODE_OPC) begin
            class_out = CDT_CLS_ENTER_BACKGROUND_OPCODE;
        end else if (illegal_in) begin
            class_out = CDT_CLS_ILLEGAL;
        end else begin
            class_out = CDT_CLS_NORMAL;
        end
    end

endmodule
`default_nettype wire

// file: verif/cdt_core_model.sv
// Core-side responder that completes debugger accesses after a set latency.
`default_nettype none
module cdt_core_model (
    // Clock, reset and latency
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic [3:0]  lat_in,
    // Access handshake
    input  wire logic        req_valid_in,
    output logic             ack_out,
    output logic      [15:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    // Answers each access once, lat_in + 1 cycles after its request rises; idle data toggles every cycle.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {cnt_q, ack_out, rdata_out} <= '0;
        end else begin
            cnt_q <= req_valid_in ? cnt_q + 4'h1 : 4'h0;
            ack_out <= req_valid_in && cnt_q == lat_in;
            rdata_out <= (req_valid_in && cnt_q == lat_in) ? 16'hc3a5 : ~rdata_out;
        end
    end
endmodule
`default_nettype wire

// file: verif/cpu_debug_trace_support_bench.sv
// Self-checking bench of the debug and trace support block.
`default_nettype none
`include "cdt_regs.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module cpu_debug_trace_support_bench;
    import cdt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, st, md, fe, fl, dn, il, fw, mem, df, be, xb_n, sck, sdi, ack;
    logic        sdo, pa, fm, ev, bg, hl, rv;
    logic [16:0] sdw;
    logic [15:0] op, rd, r_op;
    logic [7:0]  vec;
    logic [3:0]  lat;
    logic [1:0]  tm;
    cdt_req_s    rq;
    int          miscompares, n_checks, cyc;
    logic [15:0] ops [9] = '{16'h4847, 16'h4848, 16'h484c, 16'h484f, 16'h4850,
                             16'ha123, 16'hf000, 16'h4aff, 16'h1234};
    // Design and the core-side responder.
    cdt_top cdt_top_inst (.clock_in(clk), .nrst_in(rst_n), .instr_start_in(st),
        .mid_advance_in(md), .prog_fetch_in(fe), .pipe_flush_in(fl), .instr_done_in(dn),
        .opcode_in(op), .opcode_illegal_in(il), .flow_change_in(fw), .trace_mode_in(tm),
        .mem_access_in(mem), .double_fault_in(df), .enter_background_opcode_enable_in(be), .ext_breakpoint_opcode_n_in(xb_n),
        .dbg_sclk_in(sck), .dbg_sdi_in(sdi), .dbg_sdo_out(sdo), .pipe_advance_out(pa),
        .instruction_fetch_marker_out(fm), .exc_valid_out(ev), .exc_vector_out(vec),
        .background_out(bg), .halted_out(hl), .dbg_req_valid_out(rv), .dbg_req_out(rq),
        .dbg_ack_in(ack), .dbg_rdata_in(rd));
    cdt_core_model cdt_core_model_inst (.clock_in(clk), .nrst_in(rst_n), .lat_in(lat),
        .req_valid_in(rv), .ack_out(ack), .rdata_out(rd));
    // Clock of 100 ns period and a ceiling on run length.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic tick(input int n = 1);
        repeat (n) @(negedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Expected vector of a completed instruction, or -1 when none is raised.
    function automatic int model(input logic [15:0] o, input logic i, f, x, input logic [1:0] m);
        if (o >= 16'h4848 && o <= 16'h484f) return `CDT_VEC_ILLEGAL;
        if (o[15:12] == 4'ha) return `CDT_VEC_LINEA;
        if (o[15:12] == 4'hf) return `CDT_VEC_LINEF;
        if (o == `CDT_ENTER_BACKGROUND_OPCODE_OPC || i) return `CDT_VEC_ILLEGAL;
        if (x) return `CDT_VEC_EXTBKPT;
        if (m == 2'h2 || (m == 2'h1 && f)) return `CDT_VEC_TRACE;
        return -1;
    endfunction
    // One instruction boundary; the exception must pulse for exactly one cycle.
    task automatic instr(input logic [15:0] o, input logic i, f, input logic [1:0] m, input int e);
        {op, il, fw, tm, dn} = {o, i, f, m, 1'b1};
        tick();
        dn = 1'b0;
        `CHK("exc_valid", e >= 0, ev)
        if (e >= 0) `CHK("exc_vector", e[7:0], vec)
        tick();
        `CHK("exc_pulse", 1'b0, ev)
    endtask
    // One serial frame, most significant bit first; the clock rests low afterwards.
    // The returned word holds the serial output seen just before each rising clock.
    task automatic send(input logic [16:0] w, output logic [16:0] s);
        for (int b = 16; b >= 0; b--) begin
            sdi = w[b];
            tick(3);
            s[b] = sdo;
            sck = 1'b1;
            tick(3);
            sck = 1'b0;
        end
        sdi = ~sdi;
    endtask
    initial begin
        {st, md, fe, fl, dn, il, fw, mem, df, be, sck, sdi, op, tm, lat} = '0;
        {xb_n, rst_n} = 2'b10;
        void'($urandom(91468));
        repeat (4) @(posedge clk);
        tick();
        `CHK("pipe_rst", 1'b0, pa)
        `CHK("mark_rst", 1'b0, fm)
        rst_n = 1'b1;
        tick(3);
        for (int k = 0; k < 4; k++) begin
            {st, md, fe, fl} = 4'h8 >> k;
            tick();
            {st, md, fe, fl} = 4'h0;
            `CHK("pipe", k < 2, pa)
            `CHK("mark", k >= 2, fm)
        end
        $display("test 1 end");
        foreach (ops[j]) instr(ops[j], j == 8, 1'b0, 2'h0, model(ops[j], j == 8, 0, 0, 2'h0));
        for (int j = 0; j < 8; j++) begin
            r_op = 16'h3fff & 16'($urandom());
            instr(r_op, 1'b0, j[0], j[2:1], model(r_op, 1'b0, j[0], 1'b0, j[2:1]));
        end
        $display("test 2 end");
        xb_n = 1'b0;
        tick(3);
        mem = 1'b1;
        tick();
        {mem, xb_n} = 2'b01;
        instr(16'h1000, 1'b0, 1'b0, 2'h0, model(16'h1000, 0, 0, 1, 2'h0));
        instr(16'h1000, 1'b0, 1'b0, 2'h0, -1);
        $display("test 3 end");
        {be, lat} = {1'b1, 4'h1 + 4'($urandom() % 8)};
        instr(`CDT_ENTER_BACKGROUND_OPCODE_OPC, 1'b0, 1'b0, 2'h2, -1);
        `CHK("enter_background_opcode", 1'b1, bg)
        send({1'b0, `CDT_CMD_RREG, 12'h003}, sdw);
        for (int t = 0; t < 20 && rv !== 1'b1; t++) tick();
        `CHK("kind", CDT_ACC_RREG, rq.kind)
        `CHK("index", 4'h3, rq.index)
        for (int t = 0; t < 20 && rv !== 1'b0; t++) tick();
        `CHK("req_end", 1'b0, rv)
        send({1'b0, `CDT_CMD_NOP, 12'h000}, sdw);
        send({1'b0, `CDT_CMD_GO, 12'h000}, sdw);
        `CHK("sdo_frame", {1'b0, 16'hc3a5}, sdw)
        tick(6);
        `CHK("enter_background_opcode", 1'b0, bg)
        df = 1'b1;
        tick();
        df = 1'b0;
        tick();
        `CHK("enter_background_opcode", 1'b1, bg)
        `CHK("halt", 1'b0, hl)
        {df, be} = 2'b10;
        tick();
        df = 1'b0;
        tick();
        `CHK("halt_set", 1'b1, hl)
        $display("test 4 end");
        stop_test();
    end
endmodule
`default_nettype wire
